// ---- shared/alternate_pointer_cfg.svh ----
// Register map, field positions, reset values and instruction timing for the pointer unit
`ifndef ALTERNATE_POINTER_CFG_SVH
`define ALTERNATE_POINTER_CFG_SVH

// ****************
// Register indices (byte address = 4 * index)
// ****************
`define LEN_IDX 8'hE3
`define MODE_IDX 8'hE4
`define CFG_IDX 8'hE5
`define PTR0_IDX 8'hE6
`define PTR1_IDX 8'hE7

// ****************
// Field positions
// ****************
`define MODE_REDIRECT_BIT 0
`define MODE_NOINDEX_BIT 1
`define MODE_CIRC0_BIT 2
`define MODE_CIRC1_BIT 3
`define CFG_SELECT_BIT 0
`define CFG_UPD0_BIT 4
`define CFG_UPD1_BIT 5
`define CFG_DIR0_BIT 6
`define CFG_DIR1_BIT 7

// ****************
// Reset values
// ****************
`define LEN_RST 8'h00
`define MODE_RST 4'h0
`define CFG_RST 8'h00
`define PTR_RST 16'h0000

// ****************
// Addresses and opcodes
// ****************
`define REGION_B_BASE 16'h0100
`define PREFIX_BYTE 8'hA5
`define OPC_LOAD 8'h90
`define OPC_CODE 8'h93
`define OPC_INC 8'hA3
`define OPC_XRD 8'hE0
`define OPC_XWR 8'hF0

// ****************
// Instruction length and cycles
// ****************
`define BYTES_LOAD 3'h4
`define BYTES_SHORT 3'h2
`define CYC_LOAD 3'h4
`define CYC_CODE 3'h4
`define CYC_INC 3'h3
`define CYC_X_INT 3'h3
`define CYC_X_EXT 3'h5

`endif

// ---- shared/alternate_pointer_pkg.sv ----
// Types shared by the pointer unit
package alternate_pointer_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_LOAD = 3'h1,
    OP_CODE = 3'h2,
    OP_INC = 3'h3,
    OP_XRD = 3'h4,
    OP_XWR = 3'h5
  } op_t;
endpackage

// ---- shared/pointer_step_if.sv ----
// Signals between the pointer unit and one pointer stepper
`timescale 1ns/1ns
`default_nettype none
interface pointer_step_if;
  logic [15:0] ptr;
  logic [7:0] len;
  logic circ_en;
  logic dec;
  logic [15:0] nxt;
  modport owner (output ptr, output len, output circ_en, output dec, input nxt);
  modport stepper (input ptr, input len, input circ_en, input dec, output nxt);
endinterface
`default_nettype wire

// ---- verilog/pointer_step.sv ----
// Next value of one pointer with circular wrap
`timescale 1ns/1ns
`default_nettype none
`include "alternate_pointer_cfg.svh"
module pointer_step (
  // Pointer and mode
  pointer_step_if.stepper s
);
  wire [15:0] top_a = {8'h00, s.len};
  wire [15:0] top_b = `REGION_B_BASE + {8'h00, s.len};
  wire at_top = (s.ptr == top_a) || (s.ptr == top_b);
  wire at_base = (s.ptr == 16'h0000) || (s.ptr == `REGION_B_BASE);
  wire in_b = s.ptr[8];
  wire [15:0] plain_nxt = s.dec ? s.ptr - 16'h0001 : s.ptr + 16'h0001;
  wire [15:0] wrap_up = in_b ? `REGION_B_BASE : 16'h0000;
  wire [15:0] wrap_down = in_b ? top_b : top_a;

  // ****************
  // Wrap selection
  // ****************
  assign s.nxt = (s.circ_en && !s.dec && at_top) ? wrap_up :
                 (s.circ_en && s.dec && at_base) ? wrap_down :
                 plain_nxt;
endmodule
`default_nettype wire

// ---- verilog/dual_pointer_unit.sv ----
// Dual data pointer address unit with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none
`include "alternate_pointer_cfg.svh"
module dual_pointer_unit (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Instruction from the sequencer
  input wire logic op_valid,
  input wire logic op_prefixed,
  input wire logic [7:0] op_byte,
  input wire logic [15:0] op_imm,
  input wire logic [7:0] op_acc,
  input wire logic op_x_external,
  // Access result to the sequencer and memories
  output logic res_valid,
  output alternate_pointer_pkg::op_t res_op,
  output logic [15:0] res_addr,
  output logic res_dest_b,
  output logic [2:0] res_bytes,
  output logic [2:0] res_cycles,
  // Pointer state
  output logic [15:0] pointer_zero,
  output logic [15:0] pointer_one
);
  // ****************
  // Registers
  // ****************
  logic [7:0] circular_buffer_length_r;
  logic [3:0] pointer_mode_register_r;
  logic [7:0] cfg_r;
  logic [15:0] ptr_r [2];
  logic aw_got_r, w_got_r;
  logic [9:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic bvalid_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic res_valid_r;
  alternate_pointer_pkg::op_t res_op_r;
  logic [15:0] res_addr_r;
  logic res_dest_b_r;
  logic [2:0] res_bytes_r;
  logic [2:0] res_cycles_r;

  function automatic alternate_pointer_pkg::op_t decode_op(input logic [7:0] b);
    case (b)
      `OPC_LOAD: decode_op = alternate_pointer_pkg::OP_LOAD;
      `OPC_CODE: decode_op = alternate_pointer_pkg::OP_CODE;
      `OPC_INC: decode_op = alternate_pointer_pkg::OP_INC;
      `OPC_XRD: decode_op = alternate_pointer_pkg::OP_XRD;
      `OPC_XWR: decode_op = alternate_pointer_pkg::OP_XWR;
      default: decode_op = alternate_pointer_pkg::OP_NONE;
    endcase
  endfunction

  function automatic logic known_idx(input logic [9:0] i);
    known_idx = (i == {2'b00, `LEN_IDX}) || (i == {2'b00, `MODE_IDX}) || (i == {2'b00, `CFG_IDX}) ||
                (i == {2'b00, `PTR0_IDX}) || (i == {2'b00, `PTR1_IDX});
  endfunction

  // ****************
  // Mode fields
  // ****************
  wire redirect = pointer_mode_register_r[`MODE_REDIRECT_BIT];
  wire no_index = pointer_mode_register_r[`MODE_NOINDEX_BIT];
  wire [1:0] circ_en = {pointer_mode_register_r[`MODE_CIRC1_BIT],
                        pointer_mode_register_r[`MODE_CIRC0_BIT]};
  wire [1:0] upd_en = {cfg_r[`CFG_UPD1_BIT], cfg_r[`CFG_UPD0_BIT]};
  wire [1:0] dir = {cfg_r[`CFG_DIR1_BIT], cfg_r[`CFG_DIR0_BIT]};
  wire sel = cfg_r[`CFG_SELECT_BIT];

  // ****************
  // Instruction decode
  // ****************
  wire alternate_pointer_pkg::op_t op = decode_op(op_byte);
  wire use_one = sel ^ op_prefixed;
  wire [15:0] used_ptr = use_one ? ptr_r[1] : ptr_r[0];
  wire [15:0] code_addr = no_index ? used_ptr : used_ptr + {8'h00, op_acc};
  wire is_access = (op == alternate_pointer_pkg::OP_CODE) || (op == alternate_pointer_pkg::OP_XRD) || (op == alternate_pointer_pkg::OP_XWR);
  wire dest_b = redirect && use_one && is_access;
  wire take = op_valid && (op != alternate_pointer_pkg::OP_NONE);
  wire do_inc = take && (op == alternate_pointer_pkg::OP_INC);
  wire do_auto = take && is_access && (use_one ? upd_en[1] : upd_en[0]);
  wire do_load = take && (op == alternate_pointer_pkg::OP_LOAD);
  wire [2:0] x_cyc = op_x_external ? `CYC_X_EXT : `CYC_X_INT;
  wire [2:0] op_bytes = (op == alternate_pointer_pkg::OP_LOAD) ? `BYTES_LOAD : `BYTES_SHORT;
  wire [2:0] op_cycles = (op == alternate_pointer_pkg::OP_LOAD) ? `CYC_LOAD :
                         (op == alternate_pointer_pkg::OP_CODE) ? `CYC_CODE :
                         (op == alternate_pointer_pkg::OP_INC) ? `CYC_INC :
                         x_cyc;
  wire [15:0] op_addr = (op == alternate_pointer_pkg::OP_CODE) ? code_addr : used_ptr;

  // ****************
  // Pointer steppers
  // ****************
  wire [15:0] step_nxt [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_step
      pointer_step_if sif ();
      assign sif.ptr = ptr_r[g];
      assign sif.len = circular_buffer_length_r;
      assign sif.circ_en = circ_en[g];
      assign sif.dec = dir[g];
      assign step_nxt[g] = sif.nxt;
      pointer_step u_step (
        .s(sif)
      );
      wire hit = (g == 1) ? use_one : !use_one;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ptr_r[g] <= `PTR_RST;
        end else if (hit && do_load) begin
          ptr_r[g] <= op_imm;
        end else if (hit && (do_inc || do_auto)) begin
          ptr_r[g] <= step_nxt[g];
        end
      end
    end
  endgenerate

  // ****************
  // Result register
  // ****************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_valid_r <= 1'b0;
      res_op_r <= alternate_pointer_pkg::OP_NONE;
      res_addr_r <= 16'h0000;
      res_dest_b_r <= 1'b0;
      res_bytes_r <= 3'h0;
      res_cycles_r <= 3'h0;
    end else begin
      res_valid_r <= take;
      if (take) begin
        res_op_r <= op;
        res_addr_r <= op_addr;
        res_dest_b_r <= dest_b;
        res_bytes_r <= op_bytes;
        res_cycles_r <= op_cycles;
      end
    end
  end

  // ****************
  // AXI4-Lite write
  // ****************
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  wire wr_go = aw_got_r && w_got_r && !bvalid_r;
  wire wr_known = known_idx(aw_idx_r);
  wire wr_ro = (aw_idx_r == {2'b00, `PTR0_IDX}) || (aw_idx_r == {2'b00, `PTR1_IDX});
  assign awready = !aw_got_r && !bvalid_r;
  assign wready = !w_got_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_idx_r <= 10'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
    end else begin
      if (aw_hs) begin
        aw_got_r <= 1'b1;
        aw_idx_r <= awaddr[11:2];
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (wr_known && !wr_ro) ? 2'b00 : 2'b10;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      circular_buffer_length_r <= `LEN_RST;
      pointer_mode_register_r <= `MODE_RST;
      cfg_r <= `CFG_RST;
    end else if (wr_go && wstrb_r[0]) begin
      if (aw_idx_r == {2'b00, `LEN_IDX}) begin
        circular_buffer_length_r <= wdata_r[7:0];
      end
      if (aw_idx_r == {2'b00, `MODE_IDX}) begin
        pointer_mode_register_r <= wdata_r[3:0];
      end
      if (aw_idx_r == {2'b00, `CFG_IDX}) begin
        cfg_r <= wdata_r[7:0];
      end
    end
  end

  // ****************
  // AXI4-Lite read
  // ****************
  wire [9:0] ar_idx = araddr[11:2];
  wire [31:0] rd_mux = (ar_idx == {2'b00, `LEN_IDX}) ? {24'h000000, circular_buffer_length_r} :
                       (ar_idx == {2'b00, `MODE_IDX}) ? {28'h0000000, pointer_mode_register_r} :
                       (ar_idx == {2'b00, `CFG_IDX}) ? {24'h000000, cfg_r} :
                       (ar_idx == {2'b00, `PTR0_IDX}) ? {16'h0000, ptr_r[0]} :
                       (ar_idx == {2'b00, `PTR1_IDX}) ? {16'h0000, ptr_r[1]} :
                       32'h00000000;
  assign arready = !rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'b00;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= known_idx(ar_idx) ? 2'b00 : 2'b10;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************
  // Outputs
  // ****************
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign res_valid = res_valid_r;
  assign res_op = res_op_r;
  assign res_addr = res_addr_r;
  assign res_dest_b = res_dest_b_r;
  assign res_bytes = res_bytes_r;
  assign res_cycles = res_cycles_r;
  assign pointer_zero = ptr_r[0];
  assign pointer_one = ptr_r[1];
endmodule
`default_nettype wire

// ---- tb/alternate_pointer_sva.sv ----
// Assertions on the pointer unit instruction port
`timescale 1ns/1ns
`default_nettype none
`include "alternate_pointer_cfg.svh"
module alternate_pointer_chk (
  // Watched ports
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic op_x_external,
  input wire logic res_valid,
  input wire logic [2:0] res_bytes,
  input wire logic [2:0] res_cycles,
  input wire logic [15:0] pointer_zero,
  input wire logic [15:0] pointer_one
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire known = op_byte inside {`OPC_LOAD, `OPC_CODE, `OPC_INC, `OPC_XRD, `OPC_XWR};
  sequence s_op(b);
    op_valid && op_byte == b;
  endsequence
  property p_load;
    s_op(`OPC_LOAD) |=> res_bytes == `BYTES_LOAD && res_cycles == `CYC_LOAD;
  endproperty
  a_load: assert property (p_load) else $error("load length wrong");
  property p_code;
    s_op(`OPC_CODE) |=> res_bytes == `BYTES_SHORT && res_cycles == `CYC_CODE;
  endproperty
  a_code: assert property (p_code) else $error("code read length wrong");
  property p_inc;
    s_op(`OPC_INC) |=> res_bytes == `BYTES_SHORT && res_cycles == `CYC_INC;
  endproperty
  a_inc: assert property (p_inc) else $error("increment length wrong");
  property p_xrd;
    s_op(`OPC_XRD) ##0 op_x_external |=> res_cycles == `CYC_X_EXT;
  endproperty
  a_xrd: assert property (p_xrd) else $error("slow read cycles wrong");
  property p_xwr;
    s_op(`OPC_XWR) ##0 !op_x_external |=> res_cycles == `CYC_X_INT && res_bytes == `BYTES_SHORT;
  endproperty
  a_xwr: assert property (p_xwr) else $error("fast write cycles wrong");
  property p_ack;
    res_valid == $past(op_valid && known);
  endproperty
  a_ack: assert property (p_ack) else $error("result pulse wrong");
  property p_hold;
    !op_valid |=> $stable(pointer_zero) && $stable(pointer_one);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved without op");
  property p_unk;
    op_valid && !known |=> $stable(pointer_zero) && $stable(pointer_one);
  endproperty
  a_unk: assert property (p_unk) else $error("unknown op moved pointer");
endmodule
bind dual_pointer_unit alternate_pointer_chk u_alternate_pointer_chk (.aclk(aclk), .aresetn(aresetn), .op_valid(op_valid),
  .op_byte(op_byte), .op_x_external(op_x_external), .res_valid(res_valid), .res_bytes(res_bytes),
  .res_cycles(res_cycles), .pointer_zero(pointer_zero), .pointer_one(pointer_one));
`default_nettype wire

// ---- tb/seq_model.sv ----
// Instruction sequencer model feeding the pointer unit
`timescale 1ns/1ns
`default_nettype none
module seq_model (
  // Clock
  input wire logic aclk,
  // Instruction out
  output logic op_valid,
  output logic op_prefixed,
  output logic [7:0] op_byte,
  output logic [15:0] op_imm,
  output logic [7:0] op_acc,
  output logic op_x_external
);
  initial {op_valid, op_prefixed, op_byte, op_imm, op_acc, op_x_external} = 35'h0;
  task automatic send(input logic p, input logic [7:0] b, input logic [15:0] i, input logic [7:0] a,
                      input logic e);
    @(posedge aclk);
    op_valid <= 1'h1;
    {op_prefixed, op_byte, op_imm, op_acc, op_x_external} <= {p, b, i, a, e};
    @(posedge aclk);
    op_valid <= 1'h0;
    {op_prefixed, op_byte, op_imm, op_acc, op_x_external} <= ~{p, b, i, a, e};
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the pointer unit
`timescale 1ns/1ns
`default_nettype none
`include "alternate_pointer_cfg.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, res_valid, res_dest_b;
  logic op_valid, op_prefixed, op_x_external;
  logic [7:0] op_byte, op_acc;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] res_bytes, res_cycles;
  logic [15:0] op_imm, res_addr, pointer_zero, pointer_one;
  alternate_pointer_pkg::op_t res_op;
  int fail_count = 0, total_checks = 0;
  always #2 aclk = ~aclk;
  dual_pointer_unit u_dual_pointer_unit (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp, .op_valid, .op_prefixed, .op_byte, .op_imm, .op_acc, .op_x_external,
    .res_valid, .res_op, .res_addr, .res_dest_b, .res_bytes, .res_cycles, .pointer_zero, .pointer_one);
  seq_model u_seq_model (.aclk, .op_valid, .op_prefixed, .op_byte, .op_imm, .op_acc, .op_x_external);
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 100) begin
      fail_count++;
      $display("[ERR] %0t no answer", $time);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid && n < 100);
    bready <= 1'h0;
    tmo(n);
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    arvalid <= 1'h1;
    rready <= 1'h1;
    araddr <= {2'h0, idx, 2'h0};
    do begin @(posedge aclk); if (arready) arvalid <= 1'h0; n++; end while (!rvalid && n < 100);
    rready <= 1'h0;
    tmo(n);
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask
  task automatic op(input logic p, input logic [7:0] b, input logic [15:0] i, input logic [7:0] a, input logic e);
    u_seq_model.send(p, b, i, a, e);
    #1;
    `CHK(res_valid, 1'h1)
  endtask
  task automatic t_regs;
    rd(8'hE3, 32'h0, 2'h0);
    wr(8'hE3, 8'hFF, 2'h0);
    rd(8'hE3, 32'hFF, 2'h0);
    rd(8'h10, 32'h0, 2'h2);
    wr(8'hE6, 8'h01, 2'h2);
    $display("regs done");
  endtask
  task automatic t_circ;
    wr(8'hE3, 8'h03, 2'h0);
    wr(8'hE4, 8'h04, 2'h0);
    op(1'h0, `OPC_LOAD, 16'h0003, 8'h0, 1'h0);
    `CHK(pointer_zero, 16'h0003)
    `CHK(res_op, alternate_pointer_pkg::OP_LOAD)
    op(1'h0, `OPC_INC, 16'h0, 8'h0, 1'h0);
    `CHK(pointer_zero, 16'h0000)
    `CHK(res_op, alternate_pointer_pkg::OP_INC)
    wr(8'hE5, 8'h40, 2'h0);
    op(1'h0, `OPC_INC, 16'h0, 8'h0, 1'h0);
    `CHK(pointer_zero, 16'h0003)
    wr(8'hE5, 8'h00, 2'h0);
    op(1'h0, `OPC_LOAD, 16'h0050, 8'h0, 1'h0);
    op(1'h0, `OPC_INC, 16'h0, 8'h0, 1'h0);
    `CHK(pointer_zero, 16'h0051)
    op(1'h1, `OPC_LOAD, 16'h0103, 8'h0, 1'h0);
    `CHK(pointer_one, 16'h0103)
    op(1'h1, `OPC_INC, 16'h0, 8'h0, 1'h0);
    `CHK(pointer_one, 16'h0104)
    wr(8'hE4, 8'h0C, 2'h0);
    op(1'h1, `OPC_LOAD, 16'h0103, 8'h0, 1'h0);
    op(1'h1, `OPC_INC, 16'h0, 8'h0, 1'h0);
    `CHK(pointer_one, 16'h0100)
    $display("circular done");
  endtask
  task automatic t_code;
    wr(8'hE4, 8'h01, 2'h0);
    op(1'h0, `OPC_LOAD, 16'h0050, 8'h0, 1'h0);
    op(1'h0, `OPC_CODE, 16'h0, 8'h10, 1'h0);
    `CHK({res_dest_b, res_addr}, 17'h00060)
    `CHK(res_op, alternate_pointer_pkg::OP_CODE)
    op(1'h1, `OPC_CODE, 16'h0, 8'h10, 1'h0);
    `CHK({res_dest_b, res_addr}, 17'h10110)
    wr(8'hE4, 8'h03, 2'h0);
    op(1'h1, `OPC_CODE, 16'h0, 8'h10, 1'h0);
    `CHK({res_dest_b, res_addr}, 17'h10100)
    op(1'h1, `OPC_XWR, 16'h0, 8'h0, 1'h0);
    `CHK({res_dest_b, res_addr}, 17'h10100)
    `CHK(res_op, alternate_pointer_pkg::OP_XWR)
    op(1'h0, `OPC_XRD, 16'h0, 8'h0, 1'h1);
    `CHK({res_dest_b, res_addr}, 17'h00050)
    `CHK(res_op, alternate_pointer_pkg::OP_XRD)
    $display("code done");
  endtask
  task automatic t_auto;
    wr(8'hE4, 8'h04, 2'h0);
    op(1'h0, `OPC_LOAD, 16'h0003, 8'h0, 1'h0);
    wr(8'hE5, 8'h10, 2'h0);
    op(1'h0, `OPC_XRD, 16'h0, 8'h0, 1'h1);
    `CHK(res_addr, 16'h0003)
    `CHK(pointer_zero, 16'h0000)
    wr(8'hE5, 8'h01, 2'h0);
    op(1'h0, `OPC_LOAD, 16'h0077, 8'h0, 1'h0);
    `CHK(pointer_one, 16'h0077)
    u_seq_model.send(1'h0, 8'h00, 16'h1234, 8'h0, 1'h0);
    #1;
    `CHK(res_valid, 1'h0)
    `CHK(pointer_one, 16'h0077)
    $display("auto done");
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_circ();
    t_code();
    t_auto();
    tally_and_finish();
  end
endmodule
`default_nettype wire
